/* rtl/mhtr_pkg.sv */
// package: constants and types of the modem handshake timing register bank
package mhtr_pkg;

   // clock and the shared 5/3 ms tick: three ticks every 5 ms
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TICK_X3_NS    = 5000000;
   localparam int unsigned TICK_NUM      = 3;
   localparam int unsigned TICK_DEN      = TICK_X3_NS / CLK_PERIOD_NS;
   localparam int unsigned ACC_W         = 20;
   localparam int unsigned CNT_W         = 18;

   // coarse units, converted to ticks as ms * 3 / 5
   localparam int unsigned SUSPEND_UNIT_MS  = 500;
   localparam int unsigned KISS_UNIT_MS     = 10;
   localparam int unsigned SECOND_UNIT_MS   = 1000;
   localparam int unsigned TONE_DLY_X3_MS   = 160;   // 53.33 ms, times three
   localparam int unsigned SEARCH_X3_MS     = 1280;  // 426.66 ms, times three
   localparam logic [CNT_W-1:0] SUSPEND_TICKS  = CNT_W'(SUSPEND_UNIT_MS * 3 / 5);
   localparam logic [CNT_W-1:0] KISS_TICKS     = CNT_W'(KISS_UNIT_MS * 3 / 5);
   localparam logic [CNT_W-1:0] SECOND_TICKS   = CNT_W'(SECOND_UNIT_MS * 3 / 5);
   localparam logic [CNT_W-1:0] TONE_DLY_TICKS = CNT_W'(TONE_DLY_X3_MS / 5);
   localparam logic [CNT_W-1:0] SEARCH_TICKS   = CNT_W'(SEARCH_X3_MS / 5);

   // register file: index, byte offset and reset value
   localparam int NREG = 30;
   localparam int R_TONE_SEC = 0,  R_SCR_LO = 1,     R_SCR_HI = 2,    R_SUSP = 3;
   localparam int R_ANS_SCR = 4,   R_TA_CAR = 5,     R_TA_TO = 6,     R_SLV_LOSS = 7;
   localparam int R_REV_TO = 8,    R_FSK_LO = 9,     R_FSK_HI = 10,   R_ANS_DET = 11;
   localparam int R_OC_DLY = 12,   R_TONE_FINE = 13, R_ORG_SCR = 14,  R_KISS = 15;
   localparam int R_CAR_RET = 16,  R_CAR_TO = 17,    R_TONE_DLY = 18, R_CID_GAIN = 19;
   localparam int R_RING = 20,     R_INTR = 21,      R_SIG_GAIN = 22, R_SER_A = 23;
   localparam int R_PIO_A = 24,    R_PIO_B = 25,     R_PIO_DAT = 26,  R_SER_E = 27;
   localparam int R_MODE = 28,     R_PHONE = 29;

   localparam logic [7:0] REG_OFS [NREG] = '{
      8'h1e, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f,
      8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3a, 8'h3c,
      8'h62, 8'h82, 8'hdf, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he8, 8'heb};
   localparam logic [7:0] REG_RST [NREG] = '{
      8'h03, 8'h78, 8'h08, 8'h00, 8'hd2, 8'h18, 8'h00, 8'h00, 8'h00, 8'h3c,
      8'h00, 8'h3c, 8'h0c, 8'h5a, 8'ha2, 8'h30, 8'h20, 8'h3c, 8'h29, 8'h01,
      8'h41, 8'h08, 8'h0c, 8'h22, 8'h0e, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // special addresses
   localparam logic [7:0] A_LINE_V   = 8'hdb;
   localparam logic [7:0] A_WIN_LO   = 8'he5;
   localparam logic [7:0] A_WIN_HI   = 8'he6;
   localparam logic [7:0] A_DONE_LO  = 8'h40;
   localparam logic [7:0] A_DONE_HI  = 8'h41;
   localparam logic [7:0] A_OC_SNAP  = 8'h42;

   // window modes, intrusion block field and line voltage zero threshold
   localparam logic [7:0] WIN_ADDR   = 8'h00;
   localparam logic [7:0] WIN_DATA   = 8'h01;
   localparam logic [7:0] WIN_CTRL   = 8'h02;
   localparam int         BLK_LSB     = 1;
   localparam logic [1:0] BLK_SUSPEND = 2'h2;
   localparam logic signed [7:0] LV_MIN = 8'sh03;

   // timer channels
   localparam int NCH = 16;
   localparam int C_SCR2400 = 0,  C_SUSPEND = 1,  C_ANS_SCR = 2,  C_TA_CAR = 3;
   localparam int C_TA_SRCH = 4,  C_SLV_LOSS = 5, C_REV_SRCH = 6, C_FSK_DLY = 7;
   localparam int C_ANS_DET = 8,  C_OC_DLY = 9,   C_TONE_TX = 10, C_ORG_SCR = 11;
   localparam int C_KISS = 12,    C_CAR_RET = 13, C_CAR_TO = 14,  C_TONE_DLY = 15;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mhtr_bus_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [13:0] data;
      logic [7:0]  ctrl_a;
      logic [7:0]  ctrl_b;
   } mhtr_proc_t;

   typedef struct packed {
      logic [NREG-1:0][7:0]      rf;
      logic [ACC_W-1:0]          acc;
      logic                      tick;
      logic [NCH-1:0][CNT_W-1:0] cnt;
      logic [NCH-1:0]            done;
      logic [NCH-1:0]            active;
      logic [NCH-1:0]            rise;
      logic [7:0]                lv;
      logic [7:0]                oc;
      logic [7:0]                rdata;
      mhtr_proc_t                proc;
      logic                      proc_stb;
   } mhtr_state_t;

endpackage

/* rtl/mhtr_regs.sv */
// module: modem handshake timing register bank with tick-based duration timers
//
// Behaviour
// - 2400 scrambled ones: high*256+low ticks
// - suspend intrusion detect in 500ms units
// - answerer needs scrambled ones for set ticks
// - master needs turnaround carrier for set ticks
// - turnaround search 426.66ms plus timeout ticks
// - slave carrier loss time before reverse search
// - reverse turnaround search lasts timeout ticks
// - fsk connect delay high*256+low ticks
// - answer tone reported after detect ticks
// - sample loop current after overcurrent delay
// - zero seconds: use fine answer tone length
// - originator needs 1200 scrambled ones ticks
// - echo k when kissoff exceeds 10ms units
// - returning carrier needs carrier return ticks
// - abort when no carrier within seconds
// - answer tone starts after 53.33ms units
// - line voltage signed volts, zero under 3V
// - mode selects address, data or control window
// - 16-bit address, 14-bit data, write only
// - mode 2: read status, write control
// - answer tone length in one-second units
module mhtr_regs #(
   parameter int unsigned TICK_NUM = mhtr_pkg::TICK_NUM,
   parameter int unsigned TICK_DEN = mhtr_pkg::TICK_DEN
) (
   // clock and reset
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_rstn,
   // register port
   input  wire mhtr_pkg::mhtr_bus_t         i_bus,
   output logic [7:0]                       o_rdata,
   // timer run levels, one per channel
   input  wire logic [mhtr_pkg::NCH-1:0]    i_run,
   // line side samples and processor status
   input  wire logic [7:0]                  i_line_voltage,
   input  wire logic [7:0]                  i_loop_current,
   input  wire logic [7:0]                  i_proc_status,
   // timer results
   output logic [mhtr_pkg::NCH-1:0]         o_done,
   output logic [mhtr_pkg::NCH-1:0]         o_active,
   output logic [mhtr_pkg::NCH-1:0]         o_rise,
   output logic                             o_kiss_echo,
   output logic                             o_call_abort,
   output logic [7:0]                       o_oc_snapshot,
   // processor window and configuration
   output mhtr_pkg::mhtr_proc_t             o_proc,
   output logic                             o_proc_data_stb,
   output logic [mhtr_pkg::NREG-1:0][7:0]   o_cfg
);

   initial begin
      if (TICK_NUM == 0 || TICK_NUM >= TICK_DEN ||
          TICK_DEN >= (1 << mhtr_pkg::ACC_W)) begin
         $error("mhtr_regs: tick ratio out of range");
      end
   end

   localparam logic [mhtr_pkg::ACC_W-1:0] STEP = mhtr_pkg::ACC_W'(TICK_NUM);
   localparam logic [mhtr_pkg::ACC_W-1:0] WRAP = mhtr_pkg::ACC_W'(TICK_DEN);
   localparam logic [mhtr_pkg::CNT_W-1:0] CMAX = '1;

   mhtr_pkg::mhtr_state_t                 st;
   mhtr_pkg::mhtr_state_t                 next_st;
   logic [mhtr_pkg::NCH-1:0][mhtr_pkg::CNT_W-1:0] lim;
   logic [mhtr_pkg::NCH-1:0]              run;
   logic [mhtr_pkg::NCH-1:0]              strict;
   logic [7:0]                            mode;
   logic [1:0]                            blk;

   function automatic logic [mhtr_pkg::CNT_W-1:0] ext(input logic [7:0] v);
      ext = mhtr_pkg::CNT_W'(v);
   endfunction

   function automatic logic [mhtr_pkg::CNT_W-1:0] mul(
      input logic [7:0]                  v,
      input logic [mhtr_pkg::CNT_W-1:0]  u);
      logic [2*mhtr_pkg::CNT_W-1:0] p;
      p   = ext(v) * u;
      mul = p[mhtr_pkg::CNT_W-1:0];
   endfunction

   assign mode = st.rf[mhtr_pkg::R_MODE];
   assign blk  = st.rf[mhtr_pkg::R_INTR][mhtr_pkg::BLK_LSB +: 2];

   // limits in ticks, one per channel
   //
   // every limit is worked out from the stored bytes on each cycle, so a
   // write that lands while a channel is counting moves its end point at
   // once; software that wants a clean interval changes the byte while the
   // run level of that channel is low.
   //
   // coarse units (half seconds, seconds, 10 ms, 53.33 ms) are turned into
   // whole ticks by one product with a package constant; the product is
   // cut to the counter width, which is wide enough for every byte value.

   // channel 0: 2400 bps scrambled ones sent by the caller;
   // the high byte counts 256 ticks, the low byte single ticks
   assign lim[mhtr_pkg::C_SCR2400]  = {2'h0,
                                       st.rf[mhtr_pkg::R_SCR_HI],
                                       st.rf[mhtr_pkg::R_SCR_LO]};

   // channel 1: intrusion detection held off from the start of dialing,
   // in half-second units
   assign lim[mhtr_pkg::C_SUSPEND]  = mul(st.rf[mhtr_pkg::R_SUSP],
                                          mhtr_pkg::SUSPEND_TICKS);

   // channel 2: scrambled ones seen by the answerer after the pattern ends
   assign lim[mhtr_pkg::C_ANS_SCR]  = ext(st.rf[mhtr_pkg::R_ANS_SCR]);

   // channel 3: carrier a master must hold before a turnaround counts
   assign lim[mhtr_pkg::C_TA_CAR]   = ext(st.rf[mhtr_pkg::R_TA_CAR]);

   // channel 4: turnaround search, a fixed floor plus the programmed part
   assign lim[mhtr_pkg::C_TA_SRCH]  = mhtr_pkg::CNT_W'(mhtr_pkg::SEARCH_TICKS
                                      + ext(st.rf[mhtr_pkg::R_TA_TO]));

   // channel 5: carrier absence a slave waits out before a reverse search
   assign lim[mhtr_pkg::C_SLV_LOSS] = ext(st.rf[mhtr_pkg::R_SLV_LOSS]);

   // channel 6: length of the reverse turnaround search
   assign lim[mhtr_pkg::C_REV_SRCH] = ext(st.rf[mhtr_pkg::R_REV_TO]);

   // channel 7: FSK connect delay after the answer tone handshake;
   // the same high and low split as channel 0
   assign lim[mhtr_pkg::C_FSK_DLY]  = {2'h0,
                                       st.rf[mhtr_pkg::R_FSK_HI],
                                       st.rf[mhtr_pkg::R_FSK_LO]};

   // channel 8: answer tone must stand this long before it is reported
   assign lim[mhtr_pkg::C_ANS_DET]  = ext(st.rf[mhtr_pkg::R_ANS_DET]);

   // channel 9: off-hook settling before the loop current is sampled
   assign lim[mhtr_pkg::C_OC_DLY]   = ext(st.rf[mhtr_pkg::R_OC_DLY]);

   // channel 10: transmitted answer tone length;
   // seconds take precedence; the fine length only counts when seconds is zero
   assign lim[mhtr_pkg::C_TONE_TX]  = (st.rf[mhtr_pkg::R_TONE_SEC] == 8'h00) ?
                                      ext(st.rf[mhtr_pkg::R_TONE_FINE]) :
                                      mul(st.rf[mhtr_pkg::R_TONE_SEC],
                                          mhtr_pkg::SECOND_TICKS);

   // channel 11: 1200 bps scrambled ones seen by the originator
   assign lim[mhtr_pkg::C_ORG_SCR]  = ext(st.rf[mhtr_pkg::R_ORG_SCR]);

   // channel 12: kissoff tone length in 10 ms units; the tone must be
   // longer than the limit, so this channel compares strictly
   assign lim[mhtr_pkg::C_KISS]     = mul(st.rf[mhtr_pkg::R_KISS],
                                          mhtr_pkg::KISS_TICKS);

   // channel 13: a returning carrier must stand this long after a loss
   assign lim[mhtr_pkg::C_CAR_RET]  = ext(st.rf[mhtr_pkg::R_CAR_RET]);

   // channel 14: wait for carrier in whole seconds before the call aborts
   assign lim[mhtr_pkg::C_CAR_TO]   = mul(st.rf[mhtr_pkg::R_CAR_TO],
                                          mhtr_pkg::SECOND_TICKS);

   // channel 15: off-hook to answer tone start, in 53.33 ms units
   assign lim[mhtr_pkg::C_TONE_DLY] = mul(st.rf[mhtr_pkg::R_TONE_DLY],
                                          mhtr_pkg::TONE_DLY_TICKS);

   // suspension only runs while the block field selects it; with any other
   // field value the channel stays idle, so software never sees a stale
   // active level from a suspension that the settings do not ask for
   always_comb begin
      run = i_run;
      run[mhtr_pkg::C_SUSPEND] = i_run[mhtr_pkg::C_SUSPEND]
                                 && (blk == mhtr_pkg::BLK_SUSPEND);
      strict = '0;
      strict[mhtr_pkg::C_KISS] = 1'b1;
   end

   always_comb begin
      logic [mhtr_pkg::ACC_W:0]   sum;
      logic [mhtr_pkg::CNT_W-1:0] c;
      logic                       d;
      sum     = '0;
      c       = '0;
      d       = 1'b0;
      next_st = st;

      // fractional divider keeps the long-run tick rate exact
      //
      // the accumulator adds the numerator each cycle and wraps at the
      // denominator; the wrap cycle raises the tick for one cycle. the
      // spacing between ticks jitters by one clock, but no error builds up
      // over a long count, which matters for the second-long channels.
      // the divider is free running and shared: a channel that starts
      // between ticks loses part of its first tick, so an interval may be
      // up to one tick short of the programmed figure.
      sum = {1'b0, st.acc} + {1'b0, STEP};
      if (sum >= {1'b0, WRAP}) begin
         next_st.acc  = mhtr_pkg::ACC_W'(sum - {1'b0, WRAP});
         next_st.tick = 1'b1;
      end else begin
         next_st.acc  = sum[mhtr_pkg::ACC_W-1:0];
         next_st.tick = 1'b0;
      end

      // each channel counts ticks seen while its run level holds
      //
      // a low run level clears the count, so a broken condition always
      // restarts its interval from zero; the count saturates instead of
      // wrapping, so a channel left running keeps its done level.
      for (int i = 0; i < mhtr_pkg::NCH; i++) begin
         if (!run[i]) begin
            c = '0;
         end else if (st.tick && st.cnt[i] != CMAX) begin
            c = mhtr_pkg::CNT_W'(st.cnt[i] + 1'b1);
         end else begin
            c = st.cnt[i];
         end
         d = run[i] && (strict[i] ? (c > lim[i]) : (c >= lim[i]));
         next_st.cnt[i]    = c;
         next_st.done[i]   = d;
         next_st.active[i] = run[i] && !d;
         next_st.rise[i]   = d && !st.done[i];
      end

      // loop current is captured when the off-hook delay expires
      if (next_st.rise[mhtr_pkg::C_OC_DLY]) begin
         next_st.oc = i_loop_current;
      end

      // small readings are forced to zero in both polarities
      if ($signed(i_line_voltage) < mhtr_pkg::LV_MIN &&
          $signed(i_line_voltage) > -mhtr_pkg::LV_MIN) begin
         next_st.lv = 8'h00;
      end else begin
         next_st.lv = i_line_voltage;
      end

      // register writes
      //
      // the two window offsets are not part of the register file: the
      // mode byte steers each write to the processor address, the data
      // word or the control bytes. the data word is handed over when its
      // upper part is written, so software writes the low part first.
      // modes above the control mode are reserved and writes are dropped.
      next_st.proc_stb = 1'b0;
      if (i_bus.wr) begin
         for (int r = 0; r < mhtr_pkg::NREG; r++) begin
            if (i_bus.addr == mhtr_pkg::REG_OFS[r]) begin
               next_st.rf[r] = i_bus.wdata;
            end
         end
         if (i_bus.addr == mhtr_pkg::A_WIN_LO) begin
            case (mode)
               mhtr_pkg::WIN_ADDR: next_st.proc.addr[7:0] = i_bus.wdata;
               mhtr_pkg::WIN_DATA: next_st.proc.data[7:0] = i_bus.wdata;
               mhtr_pkg::WIN_CTRL: next_st.proc.ctrl_a = i_bus.wdata;
               default: begin
               end
            endcase
         end
         if (i_bus.addr == mhtr_pkg::A_WIN_HI) begin
            case (mode)
               mhtr_pkg::WIN_ADDR: next_st.proc.addr[15:8] = i_bus.wdata;
               mhtr_pkg::WIN_DATA: begin
                  next_st.proc.data[13:8] = i_bus.wdata[5:0];
                  next_st.proc_stb        = 1'b1;
               end
               mhtr_pkg::WIN_CTRL: next_st.proc.ctrl_b = i_bus.wdata;
               default: begin
               end
            endcase
         end
      end

      // register reads; write-only window locations read as zero
      //
      // read data are registered and stand for one cycle only; the status
      // map behind the low window offset is read live in control mode.
      next_st.rdata = 8'h00;
      if (i_bus.rd) begin
         for (int r = 0; r < mhtr_pkg::NREG; r++) begin
            if (i_bus.addr == mhtr_pkg::REG_OFS[r]) begin
               next_st.rdata = st.rf[r];
            end
         end
         case (i_bus.addr)
            mhtr_pkg::A_LINE_V:  next_st.rdata = st.lv;
            mhtr_pkg::A_WIN_LO: begin
               if (mode == mhtr_pkg::WIN_CTRL) begin
                  next_st.rdata = i_proc_status;
               end
            end
            mhtr_pkg::A_DONE_LO: next_st.rdata = st.done[7:0];
            mhtr_pkg::A_DONE_HI: next_st.rdata = st.done[15:8];
            mhtr_pkg::A_OC_SNAP: next_st.rdata = st.oc;
            default: begin
            end
         endcase
      end
   end

   // synchronous reset: all timers, pulses and window targets clear, and
   // the register file takes its reset values in one edge
   always_ff @(posedge i_sys_clk) begin
      if (!i_rstn) begin
         st <= '0;
         for (int r = 0; r < mhtr_pkg::NREG; r++) begin
            st.rf[r] <= mhtr_pkg::REG_RST[r];
         end
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata         = st.rdata;
   assign o_done          = st.done;
   assign o_active        = st.active;
   assign o_rise          = st.rise;
   assign o_kiss_echo     = st.rise[mhtr_pkg::C_KISS];
   assign o_call_abort    = st.rise[mhtr_pkg::C_CAR_TO];
   assign o_oc_snapshot   = st.oc;
   assign o_proc          = st.proc;
   assign o_proc_data_stb = st.proc_stb;
   assign o_cfg           = st.rf;

endmodule

/* testbench/mhtr_regs_properties.sv */
// checker: port relations of the timing register bank
module mhtr_regs_properties (
   input wire logic                           i_sys_clk,
   input wire logic                           i_rstn,
   input wire mhtr_pkg::mhtr_bus_t            i_bus,
   input wire logic [7:0]                     o_rdata,
   input wire logic [mhtr_pkg::NCH-1:0]       i_run,
   input wire logic [mhtr_pkg::NCH-1:0]       o_done,
   input wire logic [mhtr_pkg::NCH-1:0]       o_active,
   input wire logic [mhtr_pkg::NCH-1:0]       o_rise,
   input wire logic                           o_kiss_echo,
   input wire logic                           o_call_abort,
   input wire mhtr_pkg::mhtr_proc_t           o_proc,
   input wire logic                           o_proc_data_stb,
   input wire logic [mhtr_pkg::NREG-1:0][7:0] o_cfg
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   // a window write under a given mode, as the bank sees it
   sequence s_win_wr(logic [7:0] a, logic [7:0] m);
      i_bus.wr && i_bus.addr == a && o_cfg[mhtr_pkg::R_MODE] == m;
   endsequence
   property p_rdata_idle;
      !i_bus.rd |=> o_rdata == 8'h00;
   endproperty
   property p_done_cause;
      $rose(o_done[8]) |-> $past(i_run[8]);
   endproperty
   property p_done_clear;
      o_done[3] && !i_run[3] |=> !o_done[3];
   endproperty
   property p_rise_step;
      $rose(o_done[15]) |-> o_rise[15] && !o_active[15];
   endproperty
   property p_suspend_gate;
      o_cfg[mhtr_pkg::R_INTR][2:1] != mhtr_pkg::BLK_SUSPEND |=> !o_active[1] && !o_done[1];
   endproperty
   property p_data_stb;
      s_win_wr(mhtr_pkg::A_WIN_HI, mhtr_pkg::WIN_DATA) |=>
         o_proc_data_stb && o_proc.data[13:8] == $past(i_bus.wdata[5:0]);
   endproperty
   property p_addr_low;
      s_win_wr(mhtr_pkg::A_WIN_LO, mhtr_pkg::WIN_ADDR) |=> o_proc.addr[7:0] == $past(i_bus.wdata);
   endproperty
   property p_kiss;
      o_kiss_echo == $rose(o_done[mhtr_pkg::C_KISS]);
   endproperty
   property p_abort;
      o_call_abort == $rose(o_done[mhtr_pkg::C_CAR_TO]);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   a_done_cause: assert property (p_done_cause) else $error("done without run");
   a_done_clear: assert property (p_done_clear) else $error("done kept after run");
   a_rise_step: assert property (p_rise_step) else $error("rise or active wrong");
   a_suspend_gate: assert property (p_suspend_gate) else $error("suspend not gated");
   a_data_stb: assert property (p_data_stb) else $error("data high write lost");
   a_addr_low: assert property (p_addr_low) else $error("address low write lost");
   a_kiss: assert property (p_kiss) else $error("kissoff echo wrong");
   a_abort: assert property (p_abort) else $error("call abort wrong");
endmodule

/* testbench/tb_mhtr_regs.sv */
// testbench: register access, window modes and duration timers of the timing bank
module tb_mhtr_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic                           i_sys_clk = 1'b0;
   logic                           i_rstn = 1'b0;
   mhtr_pkg::mhtr_bus_t            i_bus = '0;
   logic [mhtr_pkg::NCH-1:0]       i_run = '0;
   logic [7:0]                     i_line_voltage = 8'h00;
   logic [7:0]                     i_loop_current = 8'h5a;
   logic [7:0]                     i_proc_status = 8'hc3;
   logic [7:0]                     o_rdata, o_oc_snapshot;
   logic [mhtr_pkg::NCH-1:0]       o_done, o_active, o_rise;
   logic                           o_kiss_echo, o_call_abort, o_proc_data_stb;
   mhtr_pkg::mhtr_proc_t           o_proc;
   logic [mhtr_pkg::NREG-1:0][7:0] o_cfg;
   logic [7:0]                     lv_in [5] = '{8'hf6, 8'h02, 8'hfe, 8'h03, 8'hfd};
   logic [7:0]                     lv_exp [5] = '{8'hf6, 8'h00, 8'h00, 8'h03, 8'hfd};
   int                             err_total = 0;
   int                             check_count = 0;
   int                             cyc = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   // short tick of four cycles keeps the long counts affordable
   mhtr_regs #(.TICK_NUM(1), .TICK_DEN(4)) dut_u (.i_sys_clk, .i_rstn, .i_bus, .o_rdata,
      .i_run, .i_line_voltage, .i_loop_current, .i_proc_status, .o_done, .o_active, .o_rise,
      .o_kiss_echo, .o_call_abort, .o_oc_snapshot, .o_proc, .o_proc_data_stb, .o_cfg);
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge i_sys_clk) i_bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge i_sys_clk) i_bus <= '0;
      @(negedge i_sys_clk);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge i_sys_clk) i_bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge i_sys_clk) i_bus <= '0;
      @(negedge i_sys_clk) chk("rdata", e, o_rdata);
   endtask
   // elapsed may lose up to one partial tick, plus register latency
   task automatic tmr(int ch, logic [7:0] a1, d1, a2, d2, int l);
      int n;
      n = 0;
      wr(a1, d1);
      wr(a2, d2);
      @(posedge i_sys_clk) i_run <= i_run | (16'h1 << ch);
      @(negedge i_sys_clk);
      while (o_done[ch] !== 1'b1 && n < l * 4 + 8) begin
         @(negedge i_sys_clk);
         n++;
      end
      chk("timer_span", 1, 32'(n >= (l - 1) * 4 && n <= l * 4 + 4));
      @(posedge i_sys_clk) i_run <= i_run & ~(16'h1 << ch);
      repeat (2) @(negedge i_sys_clk);
      chk("done_clear", 0, 32'(o_done[ch]));
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      repeat (5) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      @(negedge i_sys_clk);
      for (int i = 0; i < mhtr_pkg::NREG; i++) begin
         chk("cfg_reset", mhtr_pkg::REG_RST[i], o_cfg[i]);
         rd(mhtr_pkg::REG_OFS[i], mhtr_pkg::REG_RST[i]);
      end
      $display("test reset_values done");
      for (int i = 0; i < mhtr_pkg::NREG; i++) wr(mhtr_pkg::REG_OFS[i], 8'h5a ^ 8'(i));
      for (int i = 0; i < mhtr_pkg::NREG; i++) rd(mhtr_pkg::REG_OFS[i], 8'h5a ^ 8'(i));
      rd(8'h00, 8'h00);
      $display("test read_write done");
      wr(mhtr_pkg::A_LINE_V, 8'h55);
      for (int i = 0; i < 5; i++) begin
         @(posedge i_sys_clk) i_line_voltage <= lv_in[i];
         rd(mhtr_pkg::A_LINE_V, lv_exp[i]);
      end
      $display("test line_voltage done");
      wr(8'he8, 8'h00);
      wr(8'he5, 8'h34);
      wr(8'he6, 8'h12);
      chk("proc_addr", 16'h1234, o_proc.addr);
      rd(8'he5, 8'h00);
      rd(8'he6, 8'h00);
      wr(8'he8, 8'h01);
      wr(8'he5, 8'hab);
      wr(8'he6, 8'hff);
      chk("proc_data", 14'h3fab, o_proc.data);
      wr(8'he8, 8'h02);
      rd(8'he5, 8'hc3);
      wr(8'he5, 8'h5a);
      wr(8'he6, 8'ha5);
      rd(8'he5, 8'hc3);
      chk("ctrl", 16'h5aa5, {o_proc.ctrl_a, o_proc.ctrl_b});
      wr(8'he8, 8'h03);
      wr(8'he5, 8'h77);
      chk("ignored", 16'h5a34, {o_proc.ctrl_a, o_proc.addr[7:0]});
      $display("test window done");
      wr(8'h82, 8'h08);
      @(posedge i_sys_clk) i_run <= 16'h0002;
      repeat (40) @(negedge i_sys_clk);
      chk("gated", 0, {o_active[1], o_done[1]});
      @(posedge i_sys_clk) i_run <= '0;
      tmr(0, 8'h28, 8'h01, 8'h27, 8'h02, 258);
      tmr(1, 8'h29, 8'h01, 8'h82, 8'h0c, 300);
      tmr(2, 8'h2a, 8'h03, 8'h2a, 8'h03, 3);
      tmr(3, 8'h2b, 8'h04, 8'h2b, 8'h04, 4);
      tmr(4, 8'h2c, 8'h02, 8'h2c, 8'h02, 258);
      tmr(5, 8'h2d, 8'h05, 8'h2d, 8'h05, 5);
      tmr(6, 8'h2e, 8'h06, 8'h2e, 8'h06, 6);
      tmr(7, 8'h30, 8'h01, 8'h2f, 8'h01, 257);
      tmr(8, 8'h31, 8'h07, 8'h31, 8'h07, 7);
      tmr(9, 8'h32, 8'h02, 8'h32, 8'h02, 2);
      chk("oc_snapshot", 8'h5a, o_oc_snapshot);
      tmr(10, 8'h1e, 8'h00, 8'h34, 8'h09, 9);
      tmr(10, 8'h1e, 8'h01, 8'h34, 8'h09, 600);
      tmr(11, 8'h35, 8'h08, 8'h35, 8'h08, 8);
      tmr(12, 8'h36, 8'h01, 8'h36, 8'h01, 7);
      tmr(13, 8'h37, 8'h0a, 8'h37, 8'h0a, 10);
      tmr(14, 8'h39, 8'h01, 8'h39, 8'h01, 600);
      tmr(15, 8'h3a, 8'h01, 8'h3a, 8'h01, 32);
      $display("test timers done");
      summarize();
   end
endmodule
bind mhtr_regs mhtr_regs_properties chk_u (.i_sys_clk, .i_rstn, .i_bus, .o_rdata, .i_run,
   .o_done, .o_active, .o_rise, .o_kiss_echo, .o_call_abort, .o_proc, .o_proc_data_stb, .o_cfg);
